// ===== bsp_pkg.sv
// Purpose: Constants for the buffered serial port in SPI clock-stop mode
// Assumes: 200 MHz system clock
// Notes: Used by the core, which passes the FIFO its sizes as parameters
package bsp_pkg;
    // ----------------------------------------
    // Widths and encodings
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int DIV_W = 8;
    localparam int CNT_W = 4;
    localparam logic [1:0] CLKSTOP_DELAY = 2'h2;
    localparam logic [1:0] CLKSTOP_NODELAY = 2'h3;
    localparam logic SRC_CPU = 1'h1;
    localparam logic SRC_EXT = 1'h0;
    localparam logic [DIV_W-1:0] SLAVE_DIV = 8'h01;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int MAX_BIT_MHZ = 100;
    localparam int MIN_BIT_CYCLES = (CLK_MHZ + MAX_BIT_MHZ - 1) / MAX_BIT_MHZ;
    localparam logic [CNT_W-1:0] LAST_BIT = 4'h7;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SEL = 2'h1,
        ST_SHIFT = 2'h3,
        ST_DONE = 2'h2
    } bsp_state_e;
endpackage : bsp_pkg

// ===== bsp_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, asynchronous active-low reset
// Notes: Read data come from a register
`timescale 1ns/1ps
module bsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    wire do_wr = in_valid && in_ready;
    wire mem_nonempty = (count != '0);
    wire do_load = mem_nonempty && (!out_valid || out_ready);
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_load);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            count <= next_count;
            if (do_wr) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (do_load) begin
                rd_ptr <= rd_ptr + AW'(1);
                out_data <= mem[rd_ptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule : bsp_fifo

// ===== bsp_spi.sv
// Purpose: Buffered serial port core in SPI clock-stop mode, master or slave
// Assumes: clock at 200 MHz; pins from outside pass two flip-flops
// Notes: Transmit bytes enter through a FIFO of 8 words plus its output register, 9 bytes in all
`timescale 1ns/1ps
module bsp_spi (
    input wire logic clock,
    input wire logic resetn,
    input wire logic master_mode,
    input wire logic [1:0] clock_stop_mode_sel,
    input wire logic tx_clock_polarity,
    input wire logic srg_clock_source_sel,
    input wire logic [7:0] srg_clock_divider,
    input wire logic ext_clock_in,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic busy,
    output logic tx_bit_clock_out,
    output logic tx_bit_clock_oe,
    input wire logic tx_bit_clock_in,
    output logic tx_frame_sync_out,
    output logic tx_frame_sync_oe,
    input wire logic tx_frame_sync_in,
    output logic rx_bit_clock_oe,
    input wire logic rx_bit_clock_in,
    output logic rx_frame_sync_oe,
    input wire logic rx_frame_sync_in,
    output logic data_out,
    output logic data_out_oe,
    input wire logic data_in
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] ext_s1, ext_s2;
    logic [1:0] pin_s1, pin_s2;
    logic [1:0] fs_s1, fs_s2;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ext_s1 <= '0;
            ext_s2 <= '0;
            pin_s1 <= '0;
            pin_s2 <= '0;
            fs_s1 <= 2'h3;
            fs_s2 <= 2'h3;
        end else begin
            ext_s1 <= {ext_clock_in, data_in};
            ext_s2 <= ext_s1;
            pin_s1 <= {tx_bit_clock_in, rx_bit_clock_in};
            pin_s2 <= pin_s1;
            fs_s1 <= {tx_frame_sync_in, rx_frame_sync_in};
            fs_s2 <= fs_s1;
        end
    end
    wire ext_clk = ext_s2[1];
    wire miso = ext_s2[0];
    wire slave_clk = pin_s2[1];
    wire slave_sel = !fs_s2[1] && !fs_s2[0];
    // ----------------------------------------
    // Sample-rate generator
    // ----------------------------------------
    logic ext_prev;
    wire ext_tick = ext_clk && !ext_prev;
    wire use_cpu = master_mode ? srg_clock_source_sel : bsp_pkg::SRC_CPU;
    wire srg_tick = use_cpu ? 1'b1 : ext_tick;
    wire [7:0] div_eff = master_mode ? srg_clock_divider : bsp_pkg::SLAVE_DIV;
    wire div_even = !div_eff[0] && (div_eff != 8'h00);
    // High count N/2+1 if even, else (N+1)/2; low N/2 if even, else (N+1)/2
    wire [7:0] half_n1 = 8'((9'(div_eff) + 9'h001) >> 1);
    wire [7:0] high_len = div_even ? 8'((div_eff >> 1) + 8'h01) : half_n1;
    wire [7:0] low_len = div_even ? (div_eff >> 1) : half_n1;
    // Divider at zero only legal with the external clock source or in slave mode
    wire div_ok = !(use_cpu && div_eff == 8'h00) || !master_mode;
    // ----------------------------------------
    // Transfer control
    // ----------------------------------------
    bsp_pkg::bsp_state_e state;
    bsp_pkg::bsp_state_e next_state;
    logic [7:0] phase_cnt;
    logic clk_hi;
    logic [3:0] bit_cnt;
    logic [7:0] sh_tx, sh_rx;
    logic slave_clk_prev;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_ready;
    bsp_fifo #(.WIDTH(bsp_pkg::DATA_W), .DEPTH(bsp_pkg::FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready)
    );
    wire mode_ok = (clock_stop_mode_sel == bsp_pkg::CLKSTOP_DELAY)
        || (clock_stop_mode_sel == bsp_pkg::CLKSTOP_NODELAY);
    wire nodelay = (clock_stop_mode_sel == bsp_pkg::CLKSTOP_NODELAY);
    wire phase_end = srg_tick && (phase_cnt + 8'h01 >= (clk_hi ? high_len : low_len));
    // Master edges; leading edge is where clk_hi rises and the generated clock leaves its idle level
    wire m_lead = (state == bsp_pkg::ST_SHIFT) && phase_end && !clk_hi;
    wire m_trail = (state == bsp_pkg::ST_SHIFT) && phase_end && clk_hi;
    // Slave edges seen after polarity correction
    wire s_norm = slave_clk ^ tx_clock_polarity;
    wire s_lead = !master_mode && slave_sel && s_norm && !slave_clk_prev;
    wire s_trail = !master_mode && slave_sel && !s_norm && slave_clk_prev;
    wire lead = master_mode ? m_lead : s_lead;
    wire trail = master_mode ? m_trail : s_trail;
    // Delay mode: sample lead, shift trail; no-delay mode: sample trail, shift lead
    wire do_sample = nodelay ? trail : lead;
    wire do_shift = nodelay ? lead : trail;
    // No-delay mode puts the first bit out on the first lead
    wire [7:0] tx_load = nodelay ? fifo_data : {fifo_data[6:0], 1'b0};
    wire last_bit = (bit_cnt == bsp_pkg::LAST_BIT);
    wire start_m = master_mode && mode_ok && div_ok && fifo_valid;
    wire start_s = !master_mode && mode_ok && slave_sel;
    assign fifo_ready = (state == bsp_pkg::ST_IDLE) && (start_m || start_s);
    always_comb begin
        next_state = state;
        unique case (state)
            bsp_pkg::ST_IDLE: begin
                if (start_m) begin
                    next_state = bsp_pkg::ST_SEL;
                end else if (start_s) begin
                    next_state = bsp_pkg::ST_SHIFT;
                end
            end
            bsp_pkg::ST_SEL: begin
                if (phase_end) begin
                    next_state = bsp_pkg::ST_SHIFT;
                end
            end
            bsp_pkg::ST_SHIFT: begin
                if (!master_mode && !slave_sel) begin
                    next_state = bsp_pkg::ST_IDLE;
                end else if (last_bit && trail) begin
                    next_state = bsp_pkg::ST_DONE;
                end
            end
            bsp_pkg::ST_DONE: begin
                if (!master_mode || phase_end) begin
                    next_state = bsp_pkg::ST_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= bsp_pkg::ST_IDLE;
            phase_cnt <= 8'h00;
            clk_hi <= 1'b0;
            ext_prev <= 1'b0;
            slave_clk_prev <= 1'b0;
        end else begin
            state <= next_state;
            ext_prev <= ext_clk;
            slave_clk_prev <= s_norm;
            if (state == bsp_pkg::ST_IDLE) begin
                phase_cnt <= 8'h00;
                clk_hi <= 1'b0;
            end else if (phase_end) begin
                phase_cnt <= 8'h00;
                clk_hi <= (state == bsp_pkg::ST_SHIFT) ? !clk_hi : 1'b0;
            end else if (srg_tick) begin
                phase_cnt <= phase_cnt + 8'h01;
            end
        end
    end
    // ----------------------------------------
    // Shift registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bit_cnt <= 4'h0;
            sh_tx <= 8'h00;
            sh_rx <= 8'h00;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            data_out <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (state == bsp_pkg::ST_IDLE) begin
                bit_cnt <= 4'h0;
                sh_tx <= fifo_ready ? tx_load : 8'h00;
                data_out <= fifo_ready && fifo_data[7];
            end else begin
                if (do_sample) begin
                    sh_rx <= {sh_rx[6:0], miso};
                end
                if (do_shift) begin
                    data_out <= sh_tx[7];
                    sh_tx <= {sh_tx[6:0], 1'b0};
                end
                if (trail) begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
                if (trail && last_bit) begin
                    rx_data <= nodelay ? {sh_rx[6:0], miso} : sh_rx;
                    rx_valid <= 1'b1;
                end
            end
        end
    end
    // ----------------------------------------
    // Pins
    // ----------------------------------------
    assign busy = (state != bsp_pkg::ST_IDLE);
    assign tx_bit_clock_out = clk_hi ^ tx_clock_polarity;
    assign tx_frame_sync_out = !busy;
    assign tx_bit_clock_oe = master_mode;
    assign tx_frame_sync_oe = master_mode;
    assign rx_bit_clock_oe = 1'b0;
    assign rx_frame_sync_oe = 1'b0;
    assign data_out_oe = master_mode || (busy && slave_sel);
endmodule : bsp_spi

// ===== bsp_spi_assertions.sv
// Purpose: Port checks of the SPI clock-stop core
// Assumes: One clock domain
// Notes: Bound below the module
`timescale 1ns/1ps
module bsp_spi_chk (
    input wire logic clock,
    input wire logic resetn,
    input wire logic master_mode,
    input wire logic tx_clock_polarity,
    input wire logic srg_clock_source_sel,
    input wire logic [7:0] srg_clock_divider,
    input wire logic busy,
    input wire logic tx_bit_clock_out,
    input wire logic tx_bit_clock_oe,
    input wire logic tx_frame_sync_out,
    input wire logic tx_frame_sync_oe,
    input wire logic rx_bit_clock_oe,
    input wire logic rx_frame_sync_oe,
    input wire logic data_out_oe
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    wire cpu_master = master_mode && srg_clock_source_sel;
    wire active = tx_bit_clock_out != tx_clock_polarity;
    wire div_one = cpu_master && srg_clock_divider == 8'h01;
    wire div_two = cpu_master && srg_clock_divider == 8'h02;
    wire pins_ok = tx_bit_clock_oe == master_mode && tx_frame_sync_oe == master_mode;
    sequence lead_edge;
        $changed(tx_bit_clock_out) && active;
    endsequence
    sequence back_idle;
        !active;
    endsequence
    pin_dir_a: assert property (pins_ok)
        else $error("clock or frame enable wrong");
    rx_pins_a: assert property (!rx_bit_clock_oe && !rx_frame_sync_oe)
        else $error("rx pin enabled");
    select_busy_a: assert property (master_mode |-> tx_frame_sync_out == !busy)
        else $error("select not inverse of busy");
    idle_level_a: assert property (master_mode && !busy |-> !active)
        else $error("idle clock off level");
    select_first_a: assert property (master_mode && $fell(tx_frame_sync_out) |-> !active)
        else $error("clock moved before select");
    odd_width_a: assert property (div_one and lead_edge |=> back_idle)
        else $error("odd divider width wrong");
    even_width_a: assert property (div_two and lead_edge |-> active[*2] ##1 back_idle)
        else $error("even divider width wrong");
    data_dir_a: assert property (master_mode || busy || !data_out_oe)
        else $error("slave drives data while idle");
endmodule : bsp_spi_chk
bind bsp_spi bsp_spi_chk i_bsp_spi_chk (.clock(clock), .resetn(resetn), .master_mode(master_mode),
    .tx_clock_polarity(tx_clock_polarity), .srg_clock_source_sel(srg_clock_source_sel),
    .srg_clock_divider(srg_clock_divider), .busy(busy), .tx_bit_clock_out(tx_bit_clock_out),
    .tx_bit_clock_oe(tx_bit_clock_oe), .tx_frame_sync_out(tx_frame_sync_out),
    .tx_frame_sync_oe(tx_frame_sync_oe), .rx_bit_clock_oe(rx_bit_clock_oe),
    .rx_frame_sync_oe(rx_frame_sync_oe), .data_out_oe(data_out_oe));

// ===== bsp_slave_model.sv
// Purpose: SPI slave that loops data back
// Assumes: Samples on the edge the core samples on
// Notes: Released line shows inverse of last bit
`timescale 1ns/1ps
module bsp_slave_model (
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic pol,
    input wire logic [1:0] mode,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] got
);
    logic last_bit = 1'h0;
    initial got = 8'h00;
    always @(sclk) begin
        if (!sel_n && ((sclk != pol) == (mode == 2'h2))) begin
            got <= {got[6:0], mosi};
        end
    end
    always @(mosi) begin
        if (!sel_n) begin
            last_bit = mosi;
        end
    end
    assign miso = sel_n ? ~last_bit : mosi;
endmodule : bsp_slave_model

// ===== serial_port_spi_clock_stop_mode_bench.sv
// Purpose: Self-checking bench of the SPI clock-stop core
// Assumes: 200 MHz clock
// Notes: Slave model loops data back
`timescale 1ns/1ps
module serial_port_spi_clock_stop_mode_bench;
    logic clock = 1'h0, resetn = 1'h0, master_mode = 1'h1, ext_on = 1'h0, ext_clock_in = 1'h0;
    logic [1:0] clock_stop_mode_sel = 2'h2;
    logic tx_clock_polarity = 1'h0, srg_clock_source_sel = 1'h1, tx_valid = 1'h0;
    logic [7:0] srg_clock_divider = 8'h01, tx_data = 8'h00, rx_data, got;
    logic tx_ready, rx_valid, busy, tck, tck_oe, fs_out, fs_oe, rck_oe, rfs_oe;
    logic data_out, data_out_oe, data_in, fs_in = 1'h1, rfs_in = 1'h1, sck_in = 1'h0;
    int miscompares = 0, checks_done = 0, n;
    logic [18:0] rows [8] = '{{2'h2, 1'h0, 8'h01, 8'ha5}, {2'h3, 1'h0, 8'h01, 8'h3c},
        {2'h2, 1'h1, 8'h01, 8'hc3}, {2'h3, 1'h1, 8'h01, 8'h5a}, {2'h2, 1'h0, 8'h02, 8'h81},
        {2'h3, 1'h1, 8'h02, 8'h7e}, {2'h2, 1'h0, 8'h07, 8'h96}, {2'h3, 1'h1, 8'h07, 8'h69}};
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        if (ext_on) begin
            ext_clock_in <= ~ext_clock_in;
        end
    end
    bsp_spi i_bsp_spi (.clock(clock), .resetn(resetn), .master_mode(master_mode),
        .clock_stop_mode_sel(clock_stop_mode_sel), .tx_clock_polarity(tx_clock_polarity),
        .srg_clock_source_sel(srg_clock_source_sel), .srg_clock_divider(srg_clock_divider),
        .ext_clock_in(ext_clock_in), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy),
        .tx_bit_clock_out(tck), .tx_bit_clock_oe(tck_oe), .tx_bit_clock_in(sck_in),
        .tx_frame_sync_out(fs_out), .tx_frame_sync_oe(fs_oe), .tx_frame_sync_in(fs_in),
        .rx_bit_clock_oe(rck_oe), .rx_bit_clock_in(1'h0), .rx_frame_sync_oe(rfs_oe),
        .rx_frame_sync_in(rfs_in), .data_out(data_out), .data_out_oe(data_out_oe),
        .data_in(data_in));
    bsp_slave_model i_bsp_slave_model (.sel_n(fs_out), .sclk(tck), .pol(tx_clock_polarity),
        .mode(clock_stop_mode_sel), .mosi(data_out), .miso(data_in), .got(got));
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wait_for(input bit idle, input int lim);
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while ((idle ? busy !== 1'h0 : rx_valid !== 1'h1) && k < lim);
        if (k >= lim) begin
            miscompares++;
            $display("[ERR] wait expected done seen timeout");
            end_sim();
        end
    endtask : wait_for
    task automatic put(input logic [7:0] b);
        tx_data <= b;
        tx_valid <= 1'h1;
        @(posedge clock);
        chk("tx_ready", 8'h01, {7'h0, tx_ready});
        tx_valid <= 1'h0;
    endtask : put
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        chk("busy", 8'h00, {7'h0, busy});
        chk("select", 8'h01, {7'h0, fs_out});
        foreach (rows[i]) begin
            {clock_stop_mode_sel, tx_clock_polarity, srg_clock_divider} <= rows[i][18:8];
            put(rows[i][7:0]);
            wait_for(1'b0, 400);
            if (rows[i][15:8] == 8'h07) begin
                chk("rx_data", rows[i][7:0], rx_data);
            end
            wait_for(1'b1, 100);
            chk("slave byte", rows[i][7:0], got);
        end
        srg_clock_divider <= 8'h00;
        put(8'h4d);
        repeat (40) @(posedge clock);
        chk("busy", 8'h00, {7'h0, busy});
        srg_clock_divider <= 8'h01;
        wait_for(1'b0, 400);
        wait_for(1'b1, 100);
        chk("slave byte", 8'h4d, got);
        srg_clock_source_sel <= 1'h0;
        put(8'hb2);
        repeat (40) @(posedge clock);
        chk("clock", {7'h0, tx_clock_polarity}, {7'h0, tck});
        ext_on <= 1'h1;
        wait_for(1'b0, 400);
        wait_for(1'b1, 100);
        chk("slave byte", 8'hb2, got);
        {ext_on, srg_clock_source_sel, tx_clock_polarity, clock_stop_mode_sel} <= 5'hc;
        tx_data <= 8'ha0;
        tx_valid <= 1'h1;
        n = 0;
        repeat (12) begin
            @(posedge clock);
            if (tx_ready === 1'h1) begin
                n++;
                tx_data <= 8'ha0 + 8'(n);
            end
        end
        tx_valid <= 1'h0;
        chk("accepted", 8'h09, 8'(n));
        clock_stop_mode_sel <= 2'h2;
        for (int k = 0; k < 9; k++) begin
            wait_for(1'b0, 400);
            chk("queued byte", 8'ha0 + 8'(k), got);
        end
        wait_for(1'b1, 100);
        master_mode <= 1'h0;
        sck_in <= tx_clock_polarity;
        {srg_clock_source_sel, srg_clock_divider} <= 9'h000;
        fs_in <= 1'h0;
        repeat (10) @(posedge clock);
        chk("pin enables", 8'h00, {5'h0, tck_oe, fs_oe, data_out_oe});
        chk("half select", 8'h00, {7'h0, busy});
        put(8'h9c);
        rfs_in <= 1'h0;
        n = 0;
        for (int k = 0; k < 116; k++) begin
            @(posedge clock);
            if (k % 6 == 5 && k > 16 && k < 108) begin
                sck_in <= ~sck_in;
            end
            if (rx_valid === 1'h1) begin
                n++;
            end
        end
        chk("slave frames", 8'h01, 8'(n));
        chk("slave rx", 8'h9c, rx_data);
        rfs_in <= 1'h1;
        repeat (6) @(posedge clock);
        chk("slave idle", 8'h00, {7'h0, busy});
        end_sim();
    end
endmodule : serial_port_spi_clock_stop_mode_bench
